// >>> design/pamc_pkg.sv
package pamc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_PRIO_MODE = 8'h00;
  localparam logic [7:0] OFS_AUX_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Field positions in the priority and system mode register
  localparam int BIT_BOOT_EN = 7;
  localparam int BIT_SPECIAL = 6;
  localparam int BIT_SEL_A = 5;
  localparam int BIT_RD_VIS = 4;

  // Field positions in the auxiliary and status registers
  localparam int BIT_CONV_PWR = 0;
  localparam int BIT_ST_WAIT = 0;
  localparam int BIT_ST_TIMER_OFF = 1;
  localparam int BIT_ST_STRAP = 2;

  // Reset values
  localparam logic [3:0] PSEL_RESET = 4'h5;
  localparam logic CONV_PWR_RESET = 1'b0;

  // Priority select codes and source numbering
  localparam logic [3:0] PSEL_RSVD = 4'h5;
  localparam logic [3:0] SRC_IRQ = 4'h6;
  localparam int NUM_SRC = 16;

  // Fixed maskable order, entry 0 highest, four bits per entry
  localparam logic [63:0] FIXED_ORDER = 64'h543210fedcba9876;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Mode and priority register layout
  typedef struct packed {
    logic boot_en;
    logic special;
    logic sel_a;
    logic rd_vis;
    logic [3:0] psel;
  } pamc_mode_t;

  // Winning maskable request
  typedef struct packed {
    logic valid;
    logic [3:0] id;
  } pamc_grant_t;

  // Wait instruction sequencing
  typedef enum logic [1:0] {
    WS_RUN,
    WS_STACK,
    WS_WAIT
  } pamc_wait_t;

endpackage : pamc_pkg

// >>> design/pamc_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pamc_pin_sync
  import pamc_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level_q,
  output logic ready_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [1:0] fill_q;

  // Three stages per pin; level moves only when stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        level_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Level is trusted only once every stage has seen the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 2'h0;
      ready_q <= 1'b0;
    end else if (fill_q != 2'(SYNC_STAGES)) begin
      fill_q <= fill_q + 2'h1;
    end else begin
      ready_q <= 1'b1;
    end
  end

endmodule : pamc_pin_sync
`default_nettype wire

// >>> design/pamc_prio_resolver.sv
`timescale 1ns/10ps
`default_nettype none
module pamc_prio_resolver
  import pamc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [NUM_SRC-1:0] src_en,
  input wire logic irq_mask_flag,
  input wire logic [3:0] psel,
  output pamc_grant_t grant_q
);

  logic [NUM_SRC-1:0] active;
  logic [3:0] promoted;
  pamc_grant_t grant_d;

  // Request counts only with its local enable; reserved slot never requests
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign active[i] = src_req[i] & src_en[i] & (i != int'(PSEL_RSVD));
  end

  // Reserved code falls back to the external request
  assign promoted = (psel == PSEL_RSVD) ? SRC_IRQ : psel;

  // Fixed order first, then the promoted source overrides; id stays the vector's
  always_comb begin
    grant_d = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (active[FIXED_ORDER[4*k+:4]]) begin
        grant_d.valid = 1'b1;
        grant_d.id = FIXED_ORDER[4*k+:4];
      end
    end
    if (active[promoted]) begin
      grant_d.id = promoted;
    end
    grant_d.valid = grant_d.valid & ~irq_mask_flag;
  end

  // Registered so the core sees a glitch-free winner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_d;
    end
  end

  a_mask_gates_grant: assert property (
    @(posedge pclk) disable iff (!presetn)
    grant_q.valid |-> !$past(irq_mask_flag) && (|(($past(active) >> grant_q.id) & NUM_SRC'(1))))
    else $error("grant while masked or source inactive");

endmodule : pamc_prio_resolver
`default_nettype wire

// >>> design/pamc_ctrl.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Boot ROM bit meaningful only with special mode; otherwise reads zero, ignores writes.
// - Boot ROM bit set maps loader program; clear sends that area to external bus.
// - At reset release, special mode bit loads inverse of mode pin B.
// - Software may clear the special mode bit but never set it.
// - At reset release, mode select A bit loads mode pin A.
// - Mode select A writable only in special mode; otherwise read-only until reset.
// - Pins B,A decode to single chip, expanded, bootstrap, test modes.
// - Visibility bit writable only in special mode; forced zero otherwise.
// - Visibility set shows internal reads on external data bus; clear blocks it.
// - Four-bit priority select promotes one source; writable only while mask flag set.
// - Select codes map to sources in order; reserved code acts as external request.
// - Priority select resets to code five, promoting the external request.
// - Promoted source still obeys its enable and mask flag; vector unchanged.
// - Wait instruction stacks state, halts execution, keeps oscillator running.
// - Wait ends only on unmasked interrupt or reset.
// - Mask set and watchdog off at wait entry turns timer system off.
// - Converter subsystem powers down while its power-up bit is clear.
module pamc_ctrl
  import pamc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic irq_mask_flag,
  input wire logic watchdog_supervisor_en,
  input wire logic wait_instruction,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [NUM_SRC-1:0] src_en,
  output logic irq_valid,
  output logic [3:0] irq_id,
  output logic stack_req,
  output logic cpu_halt,
  output logic wake,
  output logic osc_run,
  output logic timer_run,
  output logic converter_power,
  output logic boot_rom_map,
  output logic read_visible,
  output logic special_mode,
  output logic mode_a
);

  logic [1:0] pins_q;
  logic pins_ready_q;
  logic strap_done_q;
  pamc_mode_t mode_q;
  logic conv_pwr_q;
  pamc_wait_t wstate_q;
  logic stack_req_q;
  logic halt_q;
  logic wake_q;
  logic osc_run_q;
  logic timer_run_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  pamc_grant_t grant_q;
  logic setup;
  logic wr_acc;
  logic hit_mode;
  logic hit_aux;
  logic hit_stat;
  logic mapped;
  logic capture;
  logic ack_d;
  logic [31:0] rd_d;

  // Mode pins cross into pclk; bit 1 is pin B, bit 0 is pin A
  pamc_pin_sync #(
    .W(2)
  ) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pin({mode_pin_b, mode_pin_a}),
    .level_q(pins_q),
    .ready_q(pins_ready_q)
  );

  // Maskable priority resolution
  pamc_prio_resolver u_prio (
    .pclk(pclk),
    .presetn(presetn),
    .src_req(src_req),
    .src_en(src_en),
    .irq_mask_flag(irq_mask_flag),
    .psel(mode_q.psel),
    .grant_q(grant_q)
  );

  // Address decode; unmapped offsets answer with an error
  assign hit_mode = (paddr == ADDR_W'(OFS_PRIO_MODE));
  assign hit_aux = (paddr == ADDR_W'(OFS_AUX_CTRL));
  assign hit_stat = (paddr == ADDR_W'(OFS_STATUS));
  assign mapped = hit_mode | hit_aux | hit_stat;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;

  // Straps are taken once, the first cycle the synchronised pins are trusted
  assign capture = pins_ready_q & ~strap_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'b0;
    end else if (capture) begin
      strap_done_q <= 1'b1;
    end
  end

  // Special mode: loaded from pin B at release, software can only clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q.special <= 1'b0;
    end else if (capture) begin
      mode_q.special <= ~pins_q[1];
    end else if (wr_acc && hit_mode && !pwdata[BIT_SPECIAL]) begin
      mode_q.special <= 1'b0;
    end
  end

  // Mode select A: loaded from pin A, writable only in special mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q.sel_a <= 1'b0;
    end else if (capture) begin
      mode_q.sel_a <= pins_q[0];
    end else if (wr_acc && hit_mode && mode_q.special) begin
      mode_q.sel_a <= pwdata[BIT_SEL_A];
    end
  end

  // Boot ROM enable: set at release when bootstrap strapped or by a write in special mode, dropped with special mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q.boot_en <= 1'b0;
    end else if (capture) begin
      mode_q.boot_en <= ~pins_q[1] & ~pins_q[0];
    end else if (wr_acc && hit_mode && mode_q.special) begin
      mode_q.boot_en <= pwdata[BIT_BOOT_EN] & pwdata[BIT_SPECIAL];
    end
  end

  // Read visibility follows the same gate; clearing special mode clears it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q.rd_vis <= 1'b0;
    end else if (capture) begin
      mode_q.rd_vis <= 1'b0;
    end else if (wr_acc && hit_mode && mode_q.special) begin
      mode_q.rd_vis <= pwdata[BIT_RD_VIS] & pwdata[BIT_SPECIAL];
    end
  end

  // Priority select: writable only while the core masks interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q.psel <= PSEL_RESET;
    end else if (wr_acc && hit_mode && irq_mask_flag) begin
      mode_q.psel <= pwdata[3:0];
    end
  end

  // Converter power-up bit, cleared at reset to save current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_pwr_q <= CONV_PWR_RESET;
    end else if (wr_acc && hit_aux) begin
      conv_pwr_q <= pwdata[BIT_CONV_PWR];
    end
  end

  // Wait sequencing: one stacking cycle, then halt until an unmasked request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wstate_q <= WS_RUN;
    end else begin
      case (wstate_q)
        WS_RUN: begin
          if (wait_instruction) begin
            wstate_q <= WS_STACK;
          end
        end
        WS_STACK: begin
          wstate_q <= WS_WAIT;
        end
        WS_WAIT: begin
          if (grant_q.valid) begin
            wstate_q <= WS_RUN;
          end
        end
        default: begin
          wstate_q <= WS_RUN;
        end
      endcase
    end
  end

  // Core handshakes, each a flop so the core never sees decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_req_q <= 1'b0;
      halt_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      stack_req_q <= (wstate_q == WS_RUN) && wait_instruction;
      halt_q <= (wstate_q == WS_STACK) ||
                ((wstate_q == WS_WAIT) && !grant_q.valid);
      wake_q <= (wstate_q == WS_WAIT) && grant_q.valid;
    end
  end

  // Oscillator stops here only while in reset; otherwise only a stop mode elsewhere may gate it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= 1'b1;
    end
  end

  // Timer shutdown decided at entry, so a later mask change cannot wake it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_q <= 1'b1;
    end else if ((wstate_q == WS_RUN) && wait_instruction) begin
      timer_run_q <= !(irq_mask_flag && !watchdog_supervisor_en);
    end else if ((wstate_q == WS_WAIT) && grant_q.valid) begin
      timer_run_q <= 1'b1;
    end
  end

  // Read data; reserved bits read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_mode) begin
      rd_d[7:0] = mode_q;
    end else if (hit_aux) begin
      rd_d[BIT_CONV_PWR] = conv_pwr_q;
    end else if (hit_stat) begin
      rd_d[BIT_ST_WAIT] = halt_q;
      rd_d[BIT_ST_TIMER_OFF] = ~timer_run_q;
      rd_d[BIT_ST_STRAP] = strap_done_q;
    end
  end

  // Zero wait states once straps are in; an access begun earlier waits instead of hanging
  assign ack_d = psel & strap_done_q & ~pready_q & (setup | penable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= ack_d;
      if (ack_d) begin
        pslverr_q <= ~mapped;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_valid = grant_q.valid;
  assign irq_id = grant_q.id;
  assign stack_req = stack_req_q;
  assign cpu_halt = halt_q;
  assign wake = wake_q;
  assign osc_run = osc_run_q;
  assign timer_run = timer_run_q;
  assign converter_power = conv_pwr_q;
  assign boot_rom_map = mode_q.boot_en;
  assign read_visible = mode_q.rd_vis;
  assign special_mode = mode_q.special;
  assign mode_a = mode_q.sel_a;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_special_never_set: assert property (
    strap_done_q && $past(strap_done_q) |-> !$rose(mode_q.special))
    else $error("special mode set after strap capture");

  a_boot_needs_special: assert property (
    !mode_q.special |-> !mode_q.boot_en && !boot_rom_map)
    else $error("boot rom enabled outside special mode");

  a_vis_needs_special: assert property (
    !mode_q.special |-> !read_visible)
    else $error("read visibility outside special mode");

  a_strap_decode: assert property (
    $rose(strap_done_q) |-> mode_q.special == !$past(pins_q[1])
      && mode_q.sel_a == $past(pins_q[0])
      && mode_q.boot_en == (!$past(pins_q[1]) && !$past(pins_q[0])))
    else $error("strap decode mismatch");

  a_sel_a_locked: assert property (
    $past(strap_done_q) && !$past(mode_q.special) |-> $stable(mode_q.sel_a))
    else $error("mode select A changed outside special mode");

  a_wait_holds: assert property (
    cpu_halt && !grant_q.valid |=> cpu_halt)
    else $error("halt dropped with no request pending");

  a_psel_locked: assert property (
    !$past(irq_mask_flag) |-> $stable(mode_q.psel))
    else $error("priority select changed while unmasked");

  a_psel_reset: assert property (
    $rose(strap_done_q) |-> mode_q.psel == PSEL_RESET)
    else $error("priority select reset value wrong");

  a_wait_entry: assert property (
    (wstate_q == WS_RUN) && wait_instruction |=> stack_req ##1 cpu_halt && osc_run)
    else $error("wait entry sequence wrong");

  a_wait_exit: assert property (
    $fell(cpu_halt) |-> $past(grant_q.valid) && wake)
    else $error("wait left without unmasked request");

  a_timer_off: assert property (
    $rose(stack_req) |-> timer_run == !($past(irq_mask_flag) && !$past(watchdog_supervisor_en)))
    else $error("timer shutdown decision wrong");

endmodule : pamc_ctrl
`default_nettype wire

// >>> verification/pamc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module pamc_core_model
  import pamc_pkg::*;
(
  input wire logic pclk,
  output logic irq_mask_flag,
  output logic watchdog_supervisor_en,
  output logic wait_instruction,
  output logic [NUM_SRC-1:0] src_req,
  output logic [NUM_SRC-1:0] src_en
);
  // Core leaves reset masked, sources quiet
  initial begin
    irq_mask_flag = 1'b1;
    watchdog_supervisor_en = 1'b0;
    wait_instruction = 1'b0;
    src_req = '0;
    src_en = '0;
  end

  // Mask flag and watchdog change just after an edge
  task automatic set_cpu(input logic m, input logic wd);
    @(posedge pclk);
    irq_mask_flag <= m;
    watchdog_supervisor_en <= wd;
  endtask : set_cpu

  // Request and local enable lines of the peripherals
  task automatic set_src(input logic [NUM_SRC-1:0] r, input logic [NUM_SRC-1:0] e);
    @(posedge pclk);
    src_req <= r;
    src_en <= e;
  endtask : set_src

  // One-cycle pulse, as the core gives when it executes wait
  task automatic exec_wait();
    @(posedge pclk);
    wait_instruction <= 1'b1;
    @(posedge pclk);
    wait_instruction <= 1'b0;
  endtask : exec_wait
endmodule : pamc_core_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import pamc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, mode_pin_a, mode_pin_b, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic irq_valid, stack_req, cpu_halt, wake, osc_run, timer_run;
  logic converter_power, boot_rom_map, read_visible, special_mode, mode_a;
  logic irq_mask_flag, watchdog_supervisor_en, wait_instruction;
  logic [3:0] irq_id;
  logic [NUM_SRC-1:0] src_req, src_en;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  pamc_ctrl u_pamc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
    .irq_mask_flag(irq_mask_flag), .watchdog_supervisor_en(watchdog_supervisor_en),
    .wait_instruction(wait_instruction), .src_req(src_req), .src_en(src_en),
    .irq_valid(irq_valid), .irq_id(irq_id), .stack_req(stack_req), .cpu_halt(cpu_halt),
    .wake(wake), .osc_run(osc_run), .timer_run(timer_run), .converter_power(converter_power),
    .boot_rom_map(boot_rom_map), .read_visible(read_visible), .special_mode(special_mode),
    .mode_a(mode_a));

  pamc_core_model u_pamc_core_model (.pclk(pclk), .irq_mask_flag(irq_mask_flag),
    .watchdog_supervisor_en(watchdog_supervisor_en), .wait_instruction(wait_instruction),
    .src_req(src_req), .src_en(src_en));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Straps must be steady from release until latched
  task automatic do_reset(input logic b, input logic a);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_pin_b <= b;
    mode_pin_a <= a;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // APB transfer; no wait-state count assumed, the slave holds pready off until straps are in
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : bus_xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h00000000);
    `CHK(rd, e)
  endtask : rchk

  function automatic logic [31:0] mreg(input logic rb, sm, ma, iv, input logic [3:0] ps);
    return {24'h000000, rb, sm, ma, iv, ps};
  endfunction : mreg

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  // Every strap pair, register and mode outputs after release
  task automatic t_straps();
    logic b, a;
    for (int k = 0; k < 4; k++) begin
      {b, a} = k[1:0];
      do_reset(b, a);
      rchk(OFS_PRIO_MODE, mreg(!b && !a, !b, a, 1'b0, PSEL_RESET));
      `CHK({special_mode, mode_a, boot_rom_map, read_visible}, {!b, a, !b && !a, 1'b0})
    end
  endtask : t_straps

  // Special test mode: gated bits writable, then leave special mode
  task automatic t_special();
    do_reset(1'b0, 1'b1);
    bus_xfer(1'b1, OFS_PRIO_MODE, 32'h000000d3);
    rchk(OFS_PRIO_MODE, mreg(1'b1, 1'b1, 1'b0, 1'b1, 4'h3));
    `CHK({boot_rom_map, read_visible, mode_a}, 3'b110)
    bus_xfer(1'b1, OFS_PRIO_MODE, 32'h00000030);
    rchk(OFS_PRIO_MODE, mreg(1'b0, 1'b0, 1'b1, 1'b0, 4'h0));
    `CHK({special_mode, read_visible, boot_rom_map}, 3'b000)
    bus_xfer(1'b1, OFS_PRIO_MODE, 32'h000000ff);
    rchk(OFS_PRIO_MODE, mreg(1'b0, 1'b0, 1'b1, 1'b0, 4'hf));
  endtask : t_special

  // Single chip: mode bits locked, priority gated by mask
  task automatic t_single();
    do_reset(1'b1, 1'b0);
    bus_xfer(1'b1, OFS_PRIO_MODE, 32'h000000f7);
    `CHK(err, 1'b0)
    rchk(OFS_PRIO_MODE, mreg(1'b0, 1'b0, 1'b0, 1'b0, 4'h7));
    u_pamc_core_model.set_cpu(1'b0, 1'b0);
    bus_xfer(1'b1, OFS_PRIO_MODE, 32'h00000002);
    rchk(OFS_PRIO_MODE, mreg(1'b0, 1'b0, 1'b0, 1'b0, 4'h7));
    u_pamc_core_model.set_cpu(1'b1, 1'b0);
  endtask : t_single

  // Converter power bit and an unmapped address
  task automatic t_aux();
    bus_xfer(1'b1, OFS_AUX_CTRL, 32'h00000001);
    `CHK(converter_power, 1'b1)
    rchk(OFS_AUX_CTRL, 32'h00000001);
    bus_xfer(1'b1, OFS_AUX_CTRL, 32'h00000000);
    `CHK(converter_power, 1'b0)
    bus_xfer(1'b0, 8'h0c, 32'h00000000);
    `CHK({err, rd}, {1'b1, 32'h00000000})
  endtask : t_aux

  // Each select code promoted with all sources pending
  task automatic t_prio();
    logic [3:0] w, f;
    for (int c = 0; c < 16; c++) begin
      w = (c == 5) ? SRC_IRQ : 4'(c);
      f = (w == SRC_IRQ) ? 4'h7 : SRC_IRQ; // Top of fixed order when winner disabled, or the next one if the winner is that top
      u_pamc_core_model.set_cpu(1'b1, 1'b0);
      bus_xfer(1'b1, OFS_PRIO_MODE, {28'h0000000, 4'(c)});
      u_pamc_core_model.set_src('1, '1);
      u_pamc_core_model.set_cpu(1'b0, 1'b0);
      settle();
      `CHK({irq_valid, irq_id}, {1'b1, w})
      u_pamc_core_model.set_src('1, ~(16'h0001 << w));
      settle();
      `CHK({irq_valid, irq_id}, {1'b1, f})
      u_pamc_core_model.set_cpu(1'b1, 1'b0);
      settle();
      `CHK(irq_valid, 1'b0)
    end
  endtask : t_prio

  // Wait entry with three of the four mask/watchdog cases, ignored event, then wake
  task automatic t_wait();
    logic [2:0] tbl [3] = '{3'b100, 3'b111, 3'b001};
    for (int k = 0; k < 3; k++) begin
      u_pamc_core_model.set_src('0, '0);
      u_pamc_core_model.set_cpu(tbl[k][2], tbl[k][1]);
      u_pamc_core_model.exec_wait();
      #1;
      `CHK({stack_req, timer_run}, {1'b1, tbl[k][0]})
      @(posedge pclk);
      #1;
      `CHK({cpu_halt, osc_run, stack_req}, 3'b110)
      u_pamc_core_model.set_src(16'h0040, 16'h0000);
      settle();
      `CHK({cpu_halt, wake}, 2'b10)
      rchk(OFS_STATUS, {29'h0000000, 1'b1, !tbl[k][0], 1'b1});
      u_pamc_core_model.set_cpu(1'b0, tbl[k][1]);
      u_pamc_core_model.set_src(16'h0040, 16'h0040);
      for (int i = 0; i < 8 && wake !== 1'b1; i++) begin
        @(posedge pclk);
        #1;
      end
      `CHK({wake, cpu_halt, timer_run}, 3'b101)
      @(posedge pclk);
      #1;
      `CHK({wake, cpu_halt}, 2'b00)
    end
  endtask : t_wait

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    mode_pin_a = 1'b0;
    mode_pin_b = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_straps();
    t_special();
    t_single();
    t_aux();
    t_prio();
    t_wait();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
